// File: verilog/tpr_pkg.sv
/*
  Constants, read selects and state type for the posted timer read
  resynchroniser. Assumes one system clock that is also the timer
  interface clock; the functional clock arrives as a plain pin.
*/
// Function
// - posted reads stale right after interface restart
// - non-posted general timer reads need no wait
// - watchdog counter reads stale after restart too
// - watchdog reads always posted, no mode switch
// - sync timer counter and revision always posted
`default_nettype none

package tpr_pkg;

  localparam int DATA_W = 32;
  localparam int NUM_SHADOW = 5;
  localparam int SEL_W = 3;

  localparam logic [SEL_W-1:0] SEL_GP_COUNT = 3'h0;
  localparam logic [SEL_W-1:0] SEL_GP_CAPT1 = 3'h1;
  localparam logic [SEL_W-1:0] SEL_GP_CAPT2 = 3'h2;
  localparam logic [SEL_W-1:0] SEL_WD_COUNT = 3'h3;
  localparam logic [SEL_W-1:0] SEL_SYNC_COUNT = 3'h4;
  localparam logic [SEL_W-1:0] SEL_SYNC_REV = 3'h5;

  // interface clock cycles to wait after restart, then one functional edge
  localparam logic [1:0] IFC_WAIT_CYCLES = 2'h2;
  localparam logic [1:0] IFC_WAIT_LAST = IFC_WAIT_CYCLES - 2'h1;
  localparam logic [1:0] IFC_CNT_RESET = 2'h0;
  localparam logic [1:0] IFC_CNT_STEP = 2'h1;

  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_WAIT_IFC = 2'b01,
    ST_WAIT_FCLK = 2'b10,
    ST_SYNCED = 2'b11
  } tpr_state_t;

  // general timer registers are the only ones with a non-posted path
  function automatic logic tpr_is_gp_sel(input logic [SEL_W-1:0] sel);
    return (sel == SEL_GP_COUNT) || (sel == SEL_GP_CAPT1) ||
           (sel == SEL_GP_CAPT2);
  endfunction

endpackage

`default_nettype wire

// File: verilog/tpr_shadow.sv
/*
  Shadow store of the posted timer values with a registered read port.
  Assumes writes and reads both on the system clock.
*/
`default_nettype none

module tpr_shadow
  import tpr_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = NUM_SHADOW,
  parameter int AW = SEL_W
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic wr_en, // load all entries
  input wire logic [DEPTH-1:0][WIDTH-1:0] wr_data, // new entries
  input wire logic [AW-1:0] rd_addr, // read index
  output logic [WIDTH-1:0] rd_data // registered read data
);

  if (DEPTH > (1 << AW) || WIDTH < 1) begin : g_chk
    $error("tpr_shadow: depth does not fit address width");
  end

  // the reset word is cut from the package constant, so it caps the width
  if (WIDTH > DATA_W) begin : g_chk_w
    $error("tpr_shadow: width wider than reset word");
  end

  logic [DEPTH-1:0][WIDTH-1:0] mem_reg, mem_next;
  logic [WIDTH-1:0] rd_data_reg, rd_data_next;

  always_comb begin
    mem_next = wr_en ? wr_data : mem_reg;
    rd_data_next = DATA_RESET[WIDTH-1:0];
    if (int'(rd_addr) < DEPTH) begin
      rd_data_next = mem_reg[rd_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_reg <= '0;
      rd_data_reg <= DATA_RESET[WIDTH-1:0];
    end else begin
      mem_reg <= mem_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;

endmodule

`default_nettype wire

// File: verilog/tpr_top.sv
/*
  Read-side resynchronisation of general, watchdog and sync timer values.
  Assumes SYS_CLK is the interface clock; the functional clock, the
  interface run status and the timer values come from other domains.
*/
`default_nettype none

module tpr_top
  import tpr_pkg::*;
#(
  // arbitrary revision value
  parameter logic [DATA_W-1:0] SYNC_REVISION = 32'h0000_0001
) (
  input wire logic SYS_CLK, // interface clock, 250 MHz
  input wire logic SRST, // synchronous reset, high
  input wire logic IFACE_CLK_RUN, // interface clock running, pin
  input wire logic FUNC_CLK_IN, // timer functional clock, pin
  input wire logic GP_POSTED, // general timer posted mode select
  input wire logic [DATA_W-1:0] GP_COUNT_IN, // general counter
  input wire logic [DATA_W-1:0] GP_CAPT1_IN, // first capture
  input wire logic [DATA_W-1:0] GP_CAPT2_IN, // second capture
  input wire logic [DATA_W-1:0] WD_COUNT_IN, // watchdog counter
  input wire logic [DATA_W-1:0] SYNC_COUNT_IN, // sync timer counter
  input wire logic RD_REQ, // read request pulse
  input wire logic [SEL_W-1:0] RD_SEL, // register to read
  output logic RD_ACK, // read answer pulse
  output logic [DATA_W-1:0] RD_DATA, // read value
  output logic RD_STALE, // value may be pre-restart
  output logic RESYNC_BUSY // resync wait still running
);

  if (SEL_SYNC_REV < NUM_SHADOW) begin : g_chk
    $error("tpr_top: revision select overlaps shadow entries");
  end

  // pin synchronisers; first stage feeds the second only
  logic fclk_s1_reg, fclk_s2_reg, fclk_s3_reg;
  logic run_s1_reg, run_s2_reg;
  logic [NUM_SHADOW-1:0][DATA_W-1:0] val_in, val_s1_reg, val_s2_reg;
  logic fclk_edge;

  assign val_in = {SYNC_COUNT_IN, WD_COUNT_IN, GP_CAPT2_IN, GP_CAPT1_IN,
                   GP_COUNT_IN};

  // values are assumed steady around a functional edge; a bit-wise
  // sync would tear a word that changes while it is sampled
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      fclk_s1_reg <= 1'b0;
      fclk_s2_reg <= 1'b0;
      fclk_s3_reg <= 1'b0;
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
      val_s1_reg <= '0;
      val_s2_reg <= '0;
    end else begin
      fclk_s1_reg <= FUNC_CLK_IN;
      fclk_s2_reg <= fclk_s1_reg;
      fclk_s3_reg <= fclk_s2_reg;
      run_s1_reg <= IFACE_CLK_RUN;
      run_s2_reg <= run_s1_reg;
      val_s1_reg <= val_in;
      val_s2_reg <= val_s1_reg;
    end
  end

  assign fclk_edge = fclk_s2_reg & ~fclk_s3_reg;

  // restart tracking
  tpr_state_t state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_STOPPED: begin
        if (run_s2_reg) begin
          state_next = ST_WAIT_IFC;
          cnt_next = IFC_CNT_RESET;
        end
      end
      ST_WAIT_IFC: begin
        cnt_next = cnt_reg + IFC_CNT_STEP;
        if (cnt_reg == IFC_WAIT_LAST) begin
          state_next = ST_WAIT_FCLK;
        end
      end
      ST_WAIT_FCLK: begin
        if (fclk_edge) begin
          state_next = ST_SYNCED;
        end
      end
      ST_SYNCED: state_next = ST_SYNCED;
      default: state_next = ST_STOPPED;
    endcase
    if (!run_s2_reg) begin
      state_next = ST_STOPPED;
    end
    busy_next = (state_next != ST_SYNCED);
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_reg <= ST_STOPPED;
      cnt_reg <= IFC_CNT_RESET;
      busy_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  // shadow copies, refreshed on every functional rising edge
  logic [DATA_W-1:0] shadow_rdata;

  tpr_shadow #(
    .WIDTH(DATA_W),
    .DEPTH(NUM_SHADOW),
    .AW(SEL_W)
  ) u_shadow (
    .clk(SYS_CLK),
    .srst(SRST),
    .wr_en(fclk_edge),
    .wr_data(val_s2_reg),
    .rd_addr(RD_SEL),
    .rd_data(shadow_rdata)
  );

  // read path
  logic posted_pend_reg, posted_pend_next;
  logic np_pend_reg, np_pend_next;
  logic [SEL_W-1:0] sel_reg, sel_next;
  logic ack_reg, ack_next;
  logic stale_reg, stale_next;
  logic [DATA_W-1:0] data_reg, data_next;
  logic take_req, take_np;

  assign take_req = RD_REQ && !posted_pend_reg && !np_pend_reg;
  // watchdog and sync selects never reach the non-posted path
  assign take_np = take_req && tpr_is_gp_sel(RD_SEL) && !GP_POSTED;

  always_comb begin
    posted_pend_next = take_req && !take_np;
    np_pend_next = np_pend_reg ? !fclk_edge : take_np;
    sel_next = take_req ? RD_SEL : sel_reg;
    ack_next = 1'b0;
    stale_next = stale_reg;
    data_next = data_reg;
    if (posted_pend_reg) begin
      ack_next = 1'b1;
      // before the wait is over the shadow may predate the stop
      stale_next = (state_reg != ST_SYNCED);
      data_next = (sel_reg == SEL_SYNC_REV) ? SYNC_REVISION
                                            : shadow_rdata;
    end else if (np_pend_reg && fclk_edge) begin
      ack_next = 1'b1;
      stale_next = 1'b0;
      data_next = val_s2_reg[sel_reg];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      posted_pend_reg <= 1'b0;
      np_pend_reg <= 1'b0;
      sel_reg <= SEL_GP_COUNT;
      ack_reg <= 1'b0;
      stale_reg <= 1'b0;
      data_reg <= DATA_RESET;
    end else begin
      posted_pend_reg <= posted_pend_next;
      np_pend_reg <= np_pend_next;
      sel_reg <= sel_next;
      ack_reg <= ack_next;
      stale_reg <= stale_next;
      data_reg <= data_next;
    end
  end

  assign RD_ACK = ack_reg;
  assign RD_DATA = data_reg;
  assign RD_STALE = stale_reg;
  assign RESYNC_BUSY = busy_reg;

  property p_posted_stale;
    @(posedge SYS_CLK) disable iff (SRST)
      (posted_pend_reg && state_reg != ST_SYNCED) |=> (RD_ACK && RD_STALE);
  endproperty
  a_posted_stale: assert property (p_posted_stale)
    else $error("posted read during resync not flagged stale");

  property p_np_fresh;
    @(posedge SYS_CLK) disable iff (SRST)
      (np_pend_reg && fclk_edge) |=>
        (RD_ACK && !RD_STALE && RD_DATA == $past(val_s2_reg[sel_reg]));
  endproperty
  a_np_fresh: assert property (p_np_fresh)
    else $error("non-posted read not answered with live value");

  property p_wd_stale;
    @(posedge SYS_CLK) disable iff (SRST)
      (take_req && RD_SEL == SEL_WD_COUNT && busy_next) |->
        ##1 posted_pend_reg ##1 RD_STALE;
  endproperty
  a_wd_stale: assert property (p_wd_stale)
    else $error("watchdog read after restart not flagged stale");

  property p_wd_posted;
    @(posedge SYS_CLK) disable iff (SRST)
      (take_req && RD_SEL == SEL_WD_COUNT) |=>
        (posted_pend_reg && !np_pend_reg);
  endproperty
  a_wd_posted: assert property (p_wd_posted)
    else $error("watchdog read took non-posted path");

  property p_sync_posted;
    @(posedge SYS_CLK) disable iff (SRST)
      (take_req && !GP_POSTED &&
       (RD_SEL == SEL_SYNC_COUNT || RD_SEL == SEL_SYNC_REV)) |=>
        posted_pend_reg ##1 RD_ACK;
  endproperty
  a_sync_posted: assert property (p_sync_posted)
    else $error("sync timer read not posted");

  property p_wait_len;
    @(posedge SYS_CLK) disable iff (SRST)
      (state_reg == ST_STOPPED && run_s2_reg) |=> RESYNC_BUSY[*3];
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("resync wait shorter than required");

  property p_synced_data;
    @(posedge SYS_CLK) disable iff (SRST)
      (posted_pend_reg && state_reg == ST_SYNCED &&
       sel_reg != SEL_SYNC_REV) |=>
        (RD_ACK && !RD_STALE && RD_DATA == $past(shadow_rdata));
  endproperty
  a_synced_data: assert property (p_synced_data)
    else $error("synced posted read returned wrong value");

  property p_cov_synced;
    @(posedge SYS_CLK) disable iff (SRST) RD_ACK && !RD_STALE;
  endproperty
  c_synced: cover property (p_cov_synced);

  property p_cov_stale;
    @(posedge SYS_CLK) disable iff (SRST) RD_ACK && RD_STALE;
  endproperty
  c_stale: cover property (p_cov_stale);

  property p_cov_np;
    @(posedge SYS_CLK) disable iff (SRST) np_pend_reg && fclk_edge;
  endproperty
  c_np: cover property (p_cov_np);

endmodule

`default_nettype wire

// File: verif/tpr_reader.sv
/*
  Model of the reading bus master of the posted timer read port.
  Assumes the bench calls read() and that inputs change at falling edges.
*/
`default_nettype none

module tpr_reader
  import tpr_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic busy, // resync wait still running
  input wire logic ack, // read answer pulse
  input wire logic [DATA_W-1:0] data, // read value
  input wire logic stale, // value may be pre-restart
  output logic req, // read request pulse
  output logic [SEL_W-1:0] sel // register select
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req = 1'b0;
    sel = 3'h0;
  end

  task automatic read(input logic [SEL_W-1:0] s, input bit honour,
                      output logic [DATA_W-1:0] d, output logic st,
                      output bit ok);
    int n;
    n = 0;
    // a careful reader holds off until busy drops
    while (honour && busy !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    req = 1'b1;
    sel = s;
    @(negedge clk);
    req = 1'b0;
    // a released select must not keep showing the old code
    sel = ~s;
    n = 0;
    while (ack !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    ok = (n < 300);
    d = data;
    st = stale;
    @(negedge clk);
  endtask

endmodule

`default_nettype wire

// File: verif/tb_tpr_top.sv
/*
  Self-checking bench for the posted timer read resynchroniser.
  Assumes tpr_reader as the reading master and a slow functional clock.
*/
`default_nettype none

module tb_tpr_top;
  import tpr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [DATA_W-1:0] REV = 32'h0000_00a5; // arbitrary revision

  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic run = 1'b0;
  logic fclk = 1'b0;
  logic posted = 1'b1;
  logic [DATA_W-1:0] gp_cnt = 32'h0000_0000;
  logic [DATA_W-1:0] gp_c1 = 32'h0000_0000;
  logic [DATA_W-1:0] gp_c2 = 32'h0000_0000;
  logic [DATA_W-1:0] wd_cnt = 32'h0000_0000;
  logic [DATA_W-1:0] sy_cnt = 32'h0000_0000;
  logic req;
  logic [SEL_W-1:0] sel;
  logic ack;
  logic [DATA_W-1:0] data;
  logic stale;
  logic busy;
  int n_mismatch = 0;
  int n_tests = 0;

  always #2 sys_clk = ~sys_clk;
  // edges land on falling system edges, five system cycles apart
  always #20 fclk = ~fclk;

  tpr_top #(.SYNC_REVISION(REV)) i_dut (
    .SYS_CLK(sys_clk), .SRST(srst), .IFACE_CLK_RUN(run),
    .FUNC_CLK_IN(fclk), .GP_POSTED(posted), .GP_COUNT_IN(gp_cnt),
    .GP_CAPT1_IN(gp_c1), .GP_CAPT2_IN(gp_c2), .WD_COUNT_IN(wd_cnt),
    .SYNC_COUNT_IN(sy_cnt), .RD_REQ(req), .RD_SEL(sel), .RD_ACK(ack),
    .RD_DATA(data), .RD_STALE(stale), .RESYNC_BUSY(busy));

  tpr_reader i_rdr (.clk(sys_clk), .busy(busy), .ack(ack), .data(data),
    .stale(stale), .req(req), .sel(sel));

  function automatic logic [DATA_W-1:0] exp_val(input logic [SEL_W-1:0] s,
                                                input int k);
    case (s)
      SEL_GP_COUNT: return 32'h1000_0000 + 32'(k);
      SEL_GP_CAPT1: return 32'h2000_0000 + 32'(k);
      SEL_GP_CAPT2: return 32'h3000_0000 + 32'(k);
      SEL_WD_COUNT: return 32'h4000_0000 + 32'(k);
      SEL_SYNC_COUNT: return 32'h5000_0000 + 32'(k);
      SEL_SYNC_REV: return REV;
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic check(input string name, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic t_reset;
    check("ack_rst", DATA_W'(ack), 32'h0000_0000);
    check("data_rst", data, 32'h0000_0000);
    check("stale_rst", DATA_W'(stale), 32'h0000_0000);
    check("busy_rst", DATA_W'(busy), 32'h0000_0001);
  endtask

  // stop the interface, load new timer values, restart it
  task automatic restart(input int k);
    @(negedge sys_clk);
    run = 1'b0;
    // values move away from a functional rise so the sampler sees them whole
    @(posedge fclk);
    @(negedge sys_clk);
    gp_cnt = exp_val(SEL_GP_COUNT, k);
    gp_c1 = exp_val(SEL_GP_CAPT1, k);
    gp_c2 = exp_val(SEL_GP_CAPT2, k);
    wd_cnt = exp_val(SEL_WD_COUNT, k);
    sy_cnt = exp_val(SEL_SYNC_COUNT, k);
    repeat (4) @(negedge sys_clk);
    run = 1'b1;
    @(negedge sys_clk);
  endtask

  task automatic t_restart(input bit p, input logic [SEL_W-1:0] s,
                           input int k);
    logic [DATA_W-1:0] d;
    logic st;
    bit ok;
    posted = p;
    restart(k);
    check("busy_early", DATA_W'(busy), 32'h0000_0001);
    i_rdr.read(s, 1'b0, d, st, ok);
    check("ack_early", DATA_W'(ok), 32'h0000_0001);
    if (p || s > SEL_GP_CAPT2) begin
      check("stale_early", DATA_W'(st), 32'h0000_0001);
    end else begin
      check("stale_nonposted", DATA_W'(st), 32'h0000_0000);
      check("data_nonposted", d, exp_val(s, k));
    end
    i_rdr.read(s, 1'b1, d, st, ok);
    check("busy_done", DATA_W'(busy), 32'h0000_0000);
    check("ack_late", DATA_W'(ok), 32'h0000_0001);
    check("stale_late", DATA_W'(st), 32'h0000_0000);
    check("data_late", d, exp_val(s, k));
  endtask

  initial begin
    repeat (20) @(negedge sys_clk);
    t_reset;
    srst = 1'b0;
    for (int p = 1; p >= 0; p--) begin
      for (int s = 0; s <= 6; s++) begin
        t_restart(p[0], s[SEL_W-1:0], p * 8 + s + 1);
      end
    end
    print_verdict;
  end

  initial begin
    #50000;
    n_mismatch++;
    print_verdict;
  end

endmodule

`default_nettype wire
